//--- rtl/rmb_rate_match.v
// basic mode receive rate match fifo with low latency bypass, tx idle and signal detect
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rmb_map.vh"

module rmb_rate_match #(
  parameter DEPTH = 16,
  parameter AW = 4,
  parameter HI_MARK = 12,
  parameter LO_MARK = 4
) (
  // clock and reset
  input wire clk_sys_i,
  input wire sys_rst_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  output wire irq_o,
  // receive stream from deserializer
  input wire [8:0] rx_data_i,
  input wire rx_valid_i,
  input wire rx_sigdet_raw_i,
  // fabric read side
  input wire rd_req_i,
  output reg [8:0] rd_data_o,
  output reg rd_valid_o,
  output reg full_flag_o,
  output reg empty_flag_o,
  output wire sigdet_o,
  // transmit driver
  input wire tx_bit_i,
  input wire tx_idle_req_i,
  output reg tx_drv_o,
  output wire tx_drv_oe_o
);

  // fifo storage, no reset: only written slots are ever read
  reg [8:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;

  // control and status registers
  reg [3:0] ctrl_q;
  reg [8:0] skip_q;
  reg [3:0] stat_q;
  reg [3:0] mask_q;

  // cluster tracking on both sides
  reg [2:0] w_run_q;
  reg [2:0] w_del_q;
  reg [2:0] r_run_q;
  reg [2:0] r_ins_q;

  // flag and synchroniser state
  reg full_pend_q;
  reg sd_meta_q;
  reg sd_sync_q;

  // mode and fifo level decodes
  wire bypass = ctrl_q[`RMB_CTRL_LOWLAT];
  wire fifo_empty = (count_q == {(AW+1){1'b0}});
  wire near_full = (count_q == DEPTH[AW:0] - 1'b1);
  wire above_hi = (count_q >= HI_MARK[AW:0]);
  wire below_lo = (count_q <= LO_MARK[AW:0]);
  wire [8:0] head = mem[rd_ptr_q];

  // write side: delete a repeated skip while the fifo runs high
  wire w_skip = rx_valid_i && (rx_data_i == skip_q);
  wire w_kept_before = (w_run_q != 3'h0);
  wire w_del_room = (w_del_q < `RMB_MAX_DEL);
  wire del = w_skip && w_kept_before && w_del_room && above_hi && !bypass;

  // read side: fill when empty, repeat a skip while the fifo runs low
  wire rd_go = rd_req_i && !bypass;
  wire rd_fill = rd_go && fifo_empty;
  wire r_head_skip = (head == skip_q);
  wire r_in_run = (r_run_q != 3'h0);
  wire r_run_short = (r_run_q < `RMB_INS_LIMIT);
  wire r_ins_room = (r_ins_q < `RMB_MAX_INS);
  wire rd_ins = rd_go && !rd_fill && r_head_skip && r_in_run && r_run_short && r_ins_room && below_lo;
  wire pop = rd_go && !rd_fill && !rd_ins;

  // a byte that would fill the last slot is thrown away
  wire drop = rx_valid_i && !bypass && !del && !pop && near_full;
  // outside low latency mode, store whatever was neither deleted nor dropped
  wire push = rx_valid_i && !bypass && !del && !drop;
  wire [8:0] rd_word = rd_fill ? `RMB_FILL_CHAR : head;
  wire [3:0] events;
  assign events[`RMB_EV_DROP] = drop;
  assign events[`RMB_EV_FILL] = rd_fill;
  assign events[`RMB_EV_DEL] = del;
  assign events[`RMB_EV_INS] = rd_ins;

  // write side
  always @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr_q] <= rx_data_i;
    end
  end

  // saturating step of a cluster length counter
  localparam [2:0] RUN_MAX = 3'h7;
  function [2:0] run_step;
    input [2:0] run;
    begin
      if (run == RUN_MAX) begin
        run_step = run;
      end else begin
        run_step = run + 3'h1;
      end
    end
  endfunction

  // fifo pointers and fill level
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_ptr_q <= {AW{1'b0}};
    end else if (push) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rd_ptr_q <= {AW{1'b0}};
    end else if (pop) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  // simultaneous push and pop leave the level unchanged
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      count_q <= {(AW+1){1'b0}};
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end

  // write side cluster: kept skips in the run and deletions so far
  // the first skip of a run is always kept
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      w_run_q <= 3'h0;
      w_del_q <= 3'h0;
    end else if (rx_valid_i) begin
      if (!w_skip) begin
        w_run_q <= 3'h0;
        w_del_q <= 3'h0;
      end else if (del) begin
        w_del_q <= w_del_q + 3'h1;
      end else begin
        w_run_q <= run_step(w_run_q);
      end
    end
  end

  // read side cluster: skips output in the run and insertions so far
  // an inserted skip still counts toward the run
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      r_run_q <= 3'h0;
      r_ins_q <= 3'h0;
    end else if (rd_go) begin
      if (rd_word != skip_q) begin
        r_run_q <= 3'h0;
        r_ins_q <= 3'h0;
      end else begin
        r_run_q <= run_step(r_run_q);
        if (rd_ins) begin
          r_ins_q <= r_ins_q + 3'h1;
        end
      end
    end
  end

  // read side data path, or the receive stream in low latency mode
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 9'h000;
      rd_valid_o <= 1'b0;
    end else if (bypass) begin
      rd_data_o <= rx_data_i;
      rd_valid_o <= rx_valid_i;
    end else begin
      rd_valid_o <= rd_go;
      if (rd_go) begin
        rd_data_o <= rd_word;
      end
    end
  end

  // flags ride with the character that they describe
  always @(posedge clk_sys_i) begin
    if (sys_rst_i || bypass) begin
      full_flag_o <= 1'b0;
      empty_flag_o <= 1'b0;
    end else begin
      empty_flag_o <= rd_fill;
      full_flag_o <= rd_go && !rd_fill && full_pend_q;
    end
  end

  // a drop is remembered until the next real character is output
  always @(posedge clk_sys_i) begin
    if (sys_rst_i || bypass) begin
      full_pend_q <= 1'b0;
    end else if (drop) begin
      full_pend_q <= 1'b1;
    end else if (rd_go && !rd_fill) begin
      full_pend_q <= 1'b0;
    end
  end

  // control fields
  wire ctrl_txidle = ctrl_q[`RMB_CTRL_TXIDLE];
  wire ctrl_enc = ctrl_q[`RMB_CTRL_ENC];
  wire ctrl_sigdet = ctrl_q[`RMB_CTRL_SIGDET];

  // analog detect is asynchronous: two flops before any logic reads it
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sd_meta_q <= 1'b0;
    end else begin
      sd_meta_q <= rx_sigdet_raw_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sd_sync_q <= 1'b0;
    end else begin
      sd_sync_q <= sd_meta_q;
    end
  end

  // gated by the coder enable so that a wrong setting shows no detect
  assign sigdet_o = sd_sync_q && ctrl_sigdet && ctrl_enc;

  // transmit driver, released while the pin or the control bit asks for idle
  wire tx_idle = tx_idle_req_i || ctrl_txidle;

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tx_drv_o <= 1'b0;
    end else begin
      tx_drv_o <= tx_bit_i;
    end
  end

  assign tx_drv_oe_o = !tx_idle;

  // register address decode shared by the write and read paths
  function rmb_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      rmb_hit = (addr == ofs);
    end
  endfunction

  wire wr_stat = reg_wr_i && rmb_hit(reg_addr_i, `RMB_OFS_STAT);
  wire [3:0] stat_d;

  // sticky event bits; an event wins over a write-one clear in the same cycle
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_stat
      assign stat_d[k] = events[k] || (stat_q[k] && !(wr_stat && reg_wdata_i[k]));
    end
  endgenerate

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // writable registers; the level is read only
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl_q <= `RMB_CTRL_RST;
      skip_q <= `RMB_SKIP_RST;
      mask_q <= 4'h0;
    end else if (reg_wr_i) begin
      if (rmb_hit(reg_addr_i, `RMB_OFS_CTRL)) begin
        ctrl_q <= reg_wdata_i[3:0];
      end else if (rmb_hit(reg_addr_i, `RMB_OFS_SKIP)) begin
        skip_q <= reg_wdata_i[8:0];
      end else if (rmb_hit(reg_addr_i, `RMB_OFS_MASK)) begin
        mask_q <= reg_wdata_i[3:0];
      end
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always @(posedge clk_sys_i) begin
    if (sys_rst_i || !reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (rmb_hit(reg_addr_i, `RMB_OFS_CTRL)) begin
      reg_rdata_o <= {28'h0, ctrl_q};
    end else if (rmb_hit(reg_addr_i, `RMB_OFS_SKIP)) begin
      reg_rdata_o <= {23'h0, skip_q};
    end else if (rmb_hit(reg_addr_i, `RMB_OFS_STAT)) begin
      reg_rdata_o <= {28'h0, stat_q};
    end else if (rmb_hit(reg_addr_i, `RMB_OFS_MASK)) begin
      reg_rdata_o <= {28'h0, mask_q};
    end else if (rmb_hit(reg_addr_i, `RMB_OFS_LEVEL)) begin
      reg_rdata_o <= {{(31-AW){1'b0}}, count_q};
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  assign irq_o = |(stat_q & mask_q);

endmodule // rmb_rate_match
`default_nettype wire

//--- rtl/rmb_map.vh
// register offsets, field positions and reset values of the rate match block
`ifndef RMB_MAP_VH
`define RMB_MAP_VH
`define RMB_OFS_CTRL 8'h00
`define RMB_OFS_SKIP 8'h04
`define RMB_OFS_STAT 8'h08
`define RMB_OFS_MASK 8'h0c
`define RMB_OFS_LEVEL 8'h10
`define RMB_CTRL_LOWLAT 0
`define RMB_CTRL_TXIDLE 1
`define RMB_CTRL_ENC 2
`define RMB_CTRL_SIGDET 3
`define RMB_CTRL_RST 4'h4
`define RMB_SKIP_RST 9'h11c
`define RMB_FILL_CHAR 9'h1fe
`define RMB_MAX_DEL 3'h4
`define RMB_MAX_INS 3'h4
`define RMB_INS_LIMIT 3'h5
`define RMB_EV_DROP 0
`define RMB_EV_FILL 1
`define RMB_EV_DEL 2
`define RMB_EV_INS 3
`endif

//--- bench/rmb_rate_match_checker.sv
// port assertions of the rate match block
`timescale 1ns/1ps
`default_nettype none
module rmb_rate_match_checker (
  input wire logic clk_sys_i, sys_rst_i, reg_rd_i, rx_valid_i, rx_sigdet_raw_i, rd_req_i,
  input wire logic rd_valid_o, full_flag_o, empty_flag_o, sigdet_o, tx_idle_req_i, tx_drv_oe_o,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [8:0] rd_data_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence raw_low; !rx_sigdet_raw_i [*3]; endsequence
  fill_char_a: assert property (empty_flag_o |-> rd_data_o == 9'h1fe) else $error("bad fill");
  fill_valid_a: assert property (empty_flag_o |-> rd_valid_o && !full_flag_o) else $error("bad empty");
  full_valid_a: assert property (full_flag_o |-> rd_valid_o) else $error("bad full");
  flag_cause_a: assert property (!rd_req_i |=> !full_flag_o && !empty_flag_o) else $error("stray flag");
  quiet_out_a: assert property (!rd_req_i && !rx_valid_i |=> !rd_valid_o) else $error("stray out");
  idle_hiz_a: assert property (tx_idle_req_i |-> !tx_drv_oe_o) else $error("drive in idle");
  sigdet_low_a: assert property (raw_low |-> !sigdet_o) else $error("stray detect");
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0) else $error("stray rdata");
endmodule // rmb_rate_match_checker
bind rmb_rate_match rmb_rate_match_checker chk (.*);
`default_nettype wire

//--- bench/rmb_remote_tx.sv
// remote transmitter model driving the receive stream
`timescale 1ns/1ps
`default_nettype none
module rmb_remote_tx (
  input wire logic clk_i,
  output logic [8:0] data_o,
  output logic valid_o
);
  initial {data_o, valid_o} = 10'h0;
  // idle line carries the inverse of the last character
  task automatic send(input logic [8:0] c, input logic last);
    data_o <= c;
    valid_o <= 1'b1;
    @(posedge clk_i);
    if (last) {data_o, valid_o} <= {~c, 1'b0};
  endtask
endmodule // rmb_remote_tx
`default_nettype wire

//--- bench/basic_mode_rate_match_pcs_bench.sv
// self-checking bench of the rate match block
`timescale 1ns/1ps
`default_nettype none
module basic_mode_rate_match_pcs_bench;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_req_i = 1'b0;
  logic rx_sigdet_raw_i = 1'b0, tx_idle_req_i = 1'b0, rx_valid_i, rd_valid_o, full_flag_o, empty_flag_o;
  logic sigdet_o, irq_o, tx_drv_o, tx_drv_oe_o;
  logic tx_bit_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, v;
  logic [8:0] rx_data_i, rd_data_o;
  int error_cnt = 0, compares = 0;
  logic [39:0] rows [6] = '{40'h4, 40'h040000011c, 40'h0800000000, 40'h0c00000000, 40'h1000000000, 40'h1400000000};
  always #2 clk_sys_i = ~clk_sys_i;
  rmb_remote_tx rtx (.clk_i(clk_sys_i), .data_o(rx_data_i), .valid_o(rx_valid_i));
  rmb_rate_match dut (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, !w, a, d};
    @(posedge clk_sys_i);
    {reg_wr_i, reg_rd_i} <= 2'b00;
    #1 v = reg_rdata_o;
    @(posedge clk_sys_i);
  endtask
  task automatic take(input logic [8:0] d, input logic emp, input logic ful);
    rd_req_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_req_i <= 1'b0;
    #1 chk({rd_valid_o, empty_flag_o, full_flag_o, rd_data_o}, {1'b1, emp, ful, d});
    @(posedge clk_sys_i);
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    foreach (rows[i]) begin
      bus(1'b0, rows[i][39:32], 32'h0);
      chk(v, rows[i][31:0]);
    end
    take(9'h1fe, 1'b1, 1'b0);
    for (int i = 0; i < 16; i++) rtx.send(9'(i), i == 15);
    @(posedge clk_sys_i);
    for (int i = 0; i < 15; i++) take(9'(i), 1'b0, i == 0);
    take(9'h1fe, 1'b1, 1'b0);
    bus(1'b1, 8'h0c, 32'h1);
    chk(irq_o, 1'b1);
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk({irq_o, v[30:0]}, 32'h2);
    for (int i = 0; i < 18; i++) rtx.send(i < 12 ? 9'(i) : 9'h11c, i == 17);
    @(posedge clk_sys_i);
    bus(1'b0, 8'h10, 32'h0);
    chk(v, 32'he);
    for (int i = 0; i < 19; i++) take(i < 12 ? 9'(i) : i < 18 ? 9'h11c : 9'h1fe, i == 18, 1'b0);
    bus(1'b0, 8'h08, 32'h0);
    chk(v, 32'he);
    bus(1'b1, 8'h00, 32'h5);
    rtx.send(9'h0a5, 1'b1);
    #1 chk({rd_valid_o, rd_data_o}, 10'h2a5);
    @(posedge clk_sys_i);
    {tx_idle_req_i, rx_sigdet_raw_i} <= 2'b11;
    bus(1'b1, 8'h00, 32'hc);
    bus(1'b0, 8'h10, 32'h0);
    chk({tx_drv_oe_o, sigdet_o, v[29:0]}, 32'h40000000);
    tx_idle_req_i <= 1'b0;
    bus(1'b1, 8'h00, 32'h8);
    #1 chk({tx_drv_oe_o, sigdet_o, tx_drv_o}, 3'b100);
    @(posedge clk_sys_i);
    tx_bit_i <= 1'b1;
    @(posedge clk_sys_i);
    #1 chk(tx_drv_o, 1'b1);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    bus(1'b0, 8'h00, 32'h0);
    chk({tx_drv_o, v[30:0]}, 32'h80000004);
    complete_run();
  end
endmodule // basic_mode_rate_match_pcs_bench
`default_nettype wire
